// ==== core/lbu_uart.sv ====
/*
 lbu_uart: frame timing for a two-wire lighting bus uart, controller
 and gear roles, with register port and serial pins.
 assumes: rx pin synchronous to clock; one read or write per cycle.
*/
`timescale 1ns/1ps
module lbu_uart (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [3:0] address,
    input  wire logic [7:0] write_data,
    input  wire logic       write_strobe,
    input  wire logic       read_strobe,
    output logic      [7:0] read_data,
    input  wire logic       rx_pin,
    output logic            tx_pin
);
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_STOP  = 3'b011,
        TX_WAIT  = 3'b100
    } lbu_tx_type;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } lbu_rx_type;

    lbu_tick_if tick ();
    lbu_half_tick u_tick (.clock(clock), .reset_n(reset_n), .tick(tick));

    logic [7:0]  ctrl_one_reg, ctrl_one_next;
    logic [1:0]  stop_reg, stop_next;
    logic [8:0]  param_one_reg, param_one_next;
    logic [7:0]  param_two_reg, param_two_next;
    logic [15:0] baud_reg, baud_next;
    logic [7:0]  tx_buf_reg, tx_buf_next;
    logic        tx_buf_full_reg, tx_buf_full_next;
    logic [7:0]  shift_reg, shift_next;
    logic        shift_full_reg, shift_full_next;
    logic        kind_reg, kind_next;
    logic        armed_reg, armed_next;
    lbu_tx_type  tx_state_reg, tx_state_next;
    logic [8:0]  tx_count_reg, tx_count_next;
    logic [2:0]  tx_bit_reg, tx_bit_next;
    logic        tx_pin_reg, tx_pin_next;
    lbu_rx_type  rx_state_reg, rx_state_next;
    logic [1:0]  rx_half_reg, rx_half_next;
    logic [2:0]  rx_bit_reg, rx_bit_next;
    logic [7:0]  rx_shift_reg, rx_shift_next;
    logic [8:0]  idle_reg, idle_next;
    logic        fwd_reg, fwd_next;
    logic [7:0]  read_data_reg, read_data_next;

    logic gear_mode, ctrl_mode, line_active, rx_done, flush;
    logic fifo_push, fifo_pop, fifo_ne;
    logic [7:0] fifo_head;

    lbu_rx_fifo u_fifo (
        .clock     (clock),
        .reset_n   (reset_n),
        .flush     (1'b0),
        .push      (fifo_push),
        .push_data (rx_shift_reg),
        .pop       (fifo_pop),
        .head      (fifo_head),
        .not_empty (fifo_ne)
    );

    assign tick.divisor = baud_reg;
    assign tick.sync    = 1'b0;

    function automatic logic wr_hit(input logic [3:0] a);
        return write_strobe && (address == a);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register port

    always_comb begin
        ctrl_one_next  = ctrl_one_reg;
        stop_next      = stop_reg;
        param_one_next = param_one_reg;
        param_two_next = param_two_reg;
        baud_next      = baud_reg;
        flush          = 1'b0;
        if (wr_hit(lbu_pkg::ADDR_CONTROL_ONE)) begin
            ctrl_one_next = write_data;
        end
        if (wr_hit(lbu_pkg::ADDR_CONTROL_TWO)) begin
            stop_next = write_data[lbu_pkg::STOP_LSB +: 2];
            flush     = write_data[lbu_pkg::FLUSH_BIT];
        end
        if (wr_hit(lbu_pkg::ADDR_PARAM_ONE_LOW)) begin
            param_one_next[7:0] = write_data;
        end
        if (wr_hit(lbu_pkg::ADDR_PARAM_ONE_HIGH)) begin
            param_one_next[8] = write_data[0];
        end
        if (wr_hit(lbu_pkg::ADDR_PARAM_TWO)) begin
            param_two_next = write_data;
        end
        if (wr_hit(lbu_pkg::ADDR_BAUD_LOW)) begin
            baud_next[7:0] = write_data;
        end
        if (wr_hit(lbu_pkg::ADDR_BAUD_HIGH)) begin
            baud_next[15:8] = write_data;
        end
        fifo_pop = read_strobe && (address == lbu_pkg::ADDR_RX_BUFFER);
        read_data_next = 8'h00;
        if (read_strobe) begin
            case (address)
                lbu_pkg::ADDR_CONTROL_ONE:    read_data_next = ctrl_one_reg;
                lbu_pkg::ADDR_CONTROL_TWO:    read_data_next = {6'h00, stop_reg};
                lbu_pkg::ADDR_STATUS: begin
                    read_data_next[lbu_pkg::SHIFT_EMPTY_BIT] =
                        !shift_full_reg && (tx_state_reg == TX_IDLE
                        || tx_state_reg == TX_WAIT);
                    read_data_next[lbu_pkg::RX_FLAG_BIT]    = fifo_ne;
                    read_data_next[lbu_pkg::FRAME_KIND_BIT] = kind_reg;
                    read_data_next[lbu_pkg::TX_FULL_BIT]    = tx_buf_full_reg;
                end
                lbu_pkg::ADDR_PARAM_ONE_LOW:  read_data_next = param_one_reg[7:0];
                lbu_pkg::ADDR_PARAM_ONE_HIGH: read_data_next = {7'h00, param_one_reg[8]};
                lbu_pkg::ADDR_PARAM_TWO:      read_data_next = param_two_reg;
                lbu_pkg::ADDR_RX_BUFFER:      read_data_next = fifo_head;
                lbu_pkg::ADDR_BAUD_LOW:       read_data_next = baud_reg[7:0];
                lbu_pkg::ADDR_BAUD_HIGH:      read_data_next = baud_reg[15:8];
                default:                      read_data_next = 8'h00;
            endcase
        end
    end

    assign gear_mode = ctrl_one_reg[lbu_pkg::MODE_LSB +: 4] == lbu_pkg::MODE_GEAR
        && ctrl_one_reg[lbu_pkg::TX_ENABLE_BIT]
        && ctrl_one_reg[lbu_pkg::RX_ENABLE_BIT];
    assign ctrl_mode = ctrl_one_reg[lbu_pkg::MODE_LSB +: 4]
        == lbu_pkg::MODE_CONTROLLER;

    ////////////////////////////////////////////////////////////////////
    // receiver: samples at half-bit ticks

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_half_next  = rx_half_reg;
        rx_bit_next   = rx_bit_reg;
        rx_shift_next = rx_shift_reg;
        idle_next     = idle_reg;
        fwd_next      = fwd_reg;
        kind_next     = kind_reg;
        fifo_push     = 1'b0;
        rx_done       = 1'b0;
        line_active   = (rx_pin ^ ctrl_one_reg[lbu_pkg::RX_POL_BIT]) == 1'b0;
        if (tick.half_tick) begin
            case (rx_state_reg)
                RX_IDLE: begin
                    if (idle_reg != 9'h1FF) begin
                        idle_next = idle_reg + 9'h001;
                    end
                    if (line_active) begin
                        fwd_next = idle_reg > {1'b0, param_two_reg};
                        rx_state_next = RX_START;
                        rx_half_next  = 2'h0;
                    end
                end
                RX_START: begin
                    rx_state_next = RX_DATA;
                    rx_half_next  = 2'h0;
                    rx_bit_next   = 3'h0;
                end
                RX_DATA: begin
                    rx_half_next = rx_half_reg + 2'h1;
                    if (rx_half_reg[0]) begin
                        rx_half_next  = 2'h0;
                        rx_shift_next = {!line_active, rx_shift_reg[7:1]};
                        rx_bit_next   = rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7) begin
                            rx_state_next = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    rx_half_next = rx_half_reg + 2'h1;
                    if (rx_half_reg == 2'h2) begin
                        rx_state_next = RX_IDLE;
                        idle_next     = 9'h000;
                        rx_done       = 1'b1;
                        fifo_push     = fwd_reg || !gear_mode;
                        if (ctrl_mode) begin
                            kind_next = fwd_reg;
                        end
                    end
                end
                default: rx_state_next = RX_IDLE;
            endcase
        end
        if (fifo_push) begin
            fifo_push = 1'b1;
        end
        if (!ctrl_one_reg[lbu_pkg::RX_ENABLE_BIT]) begin
            rx_state_next = RX_IDLE;
            fifo_push     = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmitter with stop idle and parameter wait

    always_comb begin
        tx_state_next    = tx_state_reg;
        tx_count_next    = tx_count_reg;
        tx_bit_next      = tx_bit_reg;
        tx_pin_next      = tx_pin_reg;
        tx_buf_next      = tx_buf_reg;
        tx_buf_full_next = tx_buf_full_reg;
        shift_next       = shift_reg;
        shift_full_next  = shift_full_reg;
        armed_next       = armed_reg;
        if (tick.half_tick) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_pin_next = !ctrl_one_reg[lbu_pkg::TX_POL_BIT];
                    if (shift_full_reg && (!gear_mode || armed_reg)) begin
                        tx_state_next = TX_START;
                        tx_count_next = 9'h001;
                        armed_next    = 1'b0;
                        tx_pin_next   = ctrl_one_reg[lbu_pkg::TX_POL_BIT];
                    end
                end
                TX_START: begin
                    tx_count_next = tx_count_reg - 9'h001;
                    if (tx_count_reg == 9'h000) begin
                        tx_state_next = TX_DATA;
                        tx_bit_next   = 3'h0;
                        tx_count_next = 9'h001;
                        tx_pin_next = shift_reg[0] ^
                            ctrl_one_reg[lbu_pkg::TX_POL_BIT];
                    end
                end
                TX_DATA: begin
                    tx_count_next = tx_count_reg - 9'h001;
                    if (tx_count_reg == 9'h000) begin
                        tx_count_next = 9'h001;
                        tx_bit_next   = tx_bit_reg + 3'h1;
                        shift_next    = {1'b0, shift_reg[7:1]};
                        tx_pin_next = shift_reg[1] ^
                            ctrl_one_reg[lbu_pkg::TX_POL_BIT];
                        if (tx_bit_reg == 3'h7) begin
                            tx_state_next   = TX_STOP;
                            shift_full_next = 1'b0;
                            tx_pin_next = !ctrl_one_reg[lbu_pkg::TX_POL_BIT];
                            tx_count_next = {6'h00, stop_reg, 1'b0};
                        end
                    end
                end
                TX_STOP: begin
                    tx_count_next = tx_count_reg - 9'h001;
                    if (tx_count_reg <= 9'h001) begin
                        tx_state_next = TX_WAIT;
                        tx_count_next = param_one_reg;
                    end
                end
                TX_WAIT: begin
                    tx_count_next = tx_count_reg - 9'h001;
                    if (tx_count_reg <= 9'h001) begin
                        tx_state_next = TX_IDLE;
                    end
                end
                default: tx_state_next = TX_IDLE;
            endcase
        end
        if (rx_done && !gear_mode && tx_state_reg == TX_WAIT) begin
            tx_count_next = param_one_reg;
        end
        if (rx_done && gear_mode && fwd_reg) begin
            tx_state_next = TX_WAIT;
            tx_count_next = param_one_reg;
            armed_next    = 1'b1;
        end
        if (tx_state_reg == TX_WAIT && tx_state_next == TX_IDLE && gear_mode
            && !shift_full_reg) begin
            armed_next = 1'b0;
        end
        if (!shift_full_next && tx_buf_full_reg
            && (!gear_mode || tx_state_reg == TX_WAIT)) begin
            shift_next       = tx_buf_reg;
            shift_full_next  = 1'b1;
            tx_buf_full_next = 1'b0;
        end
        if (wr_hit(lbu_pkg::ADDR_TX_BUFFER)) begin
            tx_buf_next      = write_data;
            tx_buf_full_next = 1'b1;
        end
        if (flush) begin
            shift_full_next  = 1'b0;
            tx_buf_full_next = 1'b0;
            if (tx_state_reg != TX_WAIT) begin
                tx_state_next = TX_IDLE;
                tx_pin_next = !ctrl_one_reg[lbu_pkg::TX_POL_BIT];
            end
        end
        if (!ctrl_one_reg[lbu_pkg::TX_ENABLE_BIT]) begin
            tx_state_next = TX_IDLE;
            tx_pin_next   = !ctrl_one_reg[lbu_pkg::TX_POL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_one_reg    <= lbu_pkg::RESET_BYTE;
            stop_reg        <= 2'h0;
            param_one_reg   <= 9'h000;
            param_two_reg   <= lbu_pkg::RESET_BYTE;
            baud_reg        <= lbu_pkg::RESET_BAUD;
            tx_buf_reg      <= lbu_pkg::RESET_BYTE;
            tx_buf_full_reg <= 1'b0;
            shift_reg       <= lbu_pkg::RESET_BYTE;
            shift_full_reg  <= 1'b0;
            kind_reg        <= 1'b0;
            armed_reg       <= 1'b0;
            tx_state_reg    <= TX_IDLE;
            tx_count_reg    <= 9'h000;
            tx_bit_reg      <= 3'h0;
            tx_pin_reg      <= 1'b1;
            rx_state_reg    <= RX_IDLE;
            rx_half_reg     <= 2'h0;
            rx_bit_reg      <= 3'h0;
            rx_shift_reg    <= lbu_pkg::RESET_BYTE;
            idle_reg        <= 9'h000;
            fwd_reg         <= 1'b0;
            read_data_reg   <= lbu_pkg::RESET_BYTE;
        end else begin
            ctrl_one_reg    <= ctrl_one_next;
            stop_reg        <= stop_next;
            param_one_reg   <= param_one_next;
            param_two_reg   <= param_two_next;
            baud_reg        <= baud_next;
            tx_buf_reg      <= tx_buf_next;
            tx_buf_full_reg <= tx_buf_full_next;
            shift_reg       <= shift_next;
            shift_full_reg  <= shift_full_next;
            kind_reg        <= kind_next;
            armed_reg       <= armed_next;
            tx_state_reg    <= tx_state_next;
            tx_count_reg    <= tx_count_next;
            tx_bit_reg      <= tx_bit_next;
            tx_pin_reg      <= tx_pin_next;
            rx_state_reg    <= rx_state_next;
            rx_half_reg     <= rx_half_next;
            rx_bit_reg      <= rx_bit_next;
            rx_shift_reg    <= rx_shift_next;
            idle_reg        <= idle_next;
            fwd_reg         <= fwd_next;
            read_data_reg   <= read_data_next;
        end
    end

    assign read_data = read_data_reg;
    assign tx_pin    = tx_pin_reg;
endmodule // lbu_uart

// ==== core/lbu_pkg.sv ====
/*
 lbu_pkg: register map, field positions, reset values and mode codes
 for the lighting bus uart frame logic.
 assumes: an 8-bit register port with one-cycle read latency.
*/
package lbu_pkg;

    localparam logic [3:0] ADDR_CONTROL_ONE    = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_TWO    = 4'h1;
    localparam logic [3:0] ADDR_STATUS         = 4'h2;
    localparam logic [3:0] ADDR_PARAM_ONE_LOW  = 4'h3;
    localparam logic [3:0] ADDR_PARAM_ONE_HIGH = 4'h4;
    localparam logic [3:0] ADDR_PARAM_TWO      = 4'h5;
    localparam logic [3:0] ADDR_TX_BUFFER      = 4'h6;
    localparam logic [3:0] ADDR_RX_BUFFER      = 4'h7;
    localparam logic [3:0] ADDR_BAUD_LOW       = 4'h8;
    localparam logic [3:0] ADDR_BAUD_HIGH      = 4'h9;

    // control one: mode in [3:0], enables and polarities above
    localparam int MODE_LSB      = 0;
    localparam int TX_ENABLE_BIT = 4;
    localparam int RX_ENABLE_BIT = 5;
    localparam int TX_POL_BIT    = 6;
    localparam int RX_POL_BIT    = 7;
    // control two: stop bits in [1:0], flush in bit 7
    localparam int STOP_LSB      = 0;
    localparam int FLUSH_BIT     = 7;
    // status bits
    localparam int SHIFT_EMPTY_BIT = 0;
    localparam int RX_FLAG_BIT     = 1;
    localparam int FRAME_KIND_BIT  = 2;
    localparam int TX_FULL_BIT     = 3;

    localparam logic [3:0] MODE_CONTROLLER = 4'h8;
    localparam logic [3:0] MODE_GEAR       = 4'h9;
    localparam logic [1:0] STOP_TWO        = 2'h2;

    localparam logic [7:0]  RESET_BYTE   = 8'h00;
    localparam logic [15:0] RESET_BAUD   = 16'h0000;
    localparam logic [3:0]  RX_DEPTH     = 4'h4;

endpackage

// ==== core/lbu_tick_if.sv ====
/*
 lbu_tick_if: carries the half-bit tick between baud generator and core.
 assumes: single clock domain.
*/
`timescale 1ns/1ps
interface lbu_tick_if;
    logic [15:0] divisor;
    logic        half_tick;
    logic        sync;
    modport gen  (input divisor, input sync, output half_tick);
    modport user (output divisor, output sync, input half_tick);
endinterface

// ==== core/lbu_half_tick.sv ====
/*
 lbu_half_tick: divides the system clock into a half-bit enable pulse.
 assumes: divisor counts clocks per half bit minus one.
*/
`timescale 1ns/1ps
module lbu_half_tick (
    input  wire logic clock,
    input  wire logic reset_n,
    lbu_tick_if.gen   tick
);
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        count_next = count_reg - 16'h0001;
        tick_next  = 1'b0;
        if (tick.sync) begin
            count_next = tick.divisor;
        end else if (count_reg == 16'h0000) begin
            count_next = tick.divisor;
            tick_next  = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            tick_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg  <= tick_next;
        end
    end

    assign tick.half_tick = tick_reg;
endmodule // lbu_half_tick

// ==== core/lbu_rx_fifo.sv ====
/*
 lbu_rx_fifo: small receive fifo for received frame bytes.
 assumes: push and pop are single-cycle strobes.
*/
`timescale 1ns/1ps
module lbu_rx_fifo (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       flush,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    input  wire logic       pop,
    output logic      [7:0] head,
    output logic            not_empty
);
    logic [7:0] mem_reg [4];
    logic [1:0] wr_reg;
    logic [1:0] rd_reg;
    logic [2:0] fill_reg;
    logic [1:0] wr_next;
    logic [1:0] rd_next;
    logic [2:0] fill_next;
    logic       do_push;
    logic       do_pop;

    always_comb begin
        do_push   = push && (fill_reg != 3'(lbu_pkg::RX_DEPTH));
        do_pop    = pop && (fill_reg != 3'h0);
        wr_next   = do_push ? wr_reg + 2'h1 : wr_reg;
        rd_next   = do_pop ? rd_reg + 2'h1 : rd_reg;
        fill_next = fill_reg + 3'(do_push) - 3'(do_pop);
        if (flush) begin
            wr_next   = 2'h0;
            rd_next   = 2'h0;
            fill_next = 3'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_reg   <= 2'h0;
            rd_reg   <= 2'h0;
            fill_reg <= 3'h0;
        end else begin
            wr_reg   <= wr_next;
            rd_reg   <= rd_next;
            fill_reg <= fill_next;
        end
    end

    always_ff @(posedge clock) begin
        if (do_push && !flush) begin
            mem_reg[wr_reg] <= push_data;
        end
    end

    assign head      = mem_reg[rd_reg];
    assign not_empty = (fill_reg != 3'h0);
endmodule // lbu_rx_fifo

// ==== test/lbu_uart_props.sv ====
/* lbu_uart_props: port checks for lbu_uart.
   assumes: half bit of 4 clocks, tx line idles high. */
`timescale 1ns/1ps
module lbu_uart_props (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic [3:0] address,
    input wire logic [7:0] write_data,
    input wire logic       write_strobe,
    input wire logic       read_strobe,
    input wire logic [7:0] read_data,
    input wire logic       rx_pin,
    input wire logic       tx_pin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    sequence s_wr(a);
        write_strobe && address == a;
    endsequence
    sequence s_rd(a);
        read_strobe && address == a;
    endsequence
    property p_back(a);
        s_wr(a) ##1 s_rd(a) |=> read_data == $past(write_data, 2);
    endproperty
    a_read_idle: assert property (!$past(read_strobe)
        |-> read_data == 8'h00) else $error("stale read data");
    a_unmapped_zero: assert property (read_strobe
        && address > 4'h9 |=> read_data == 8'h00) else $error("unmapped");
    a_top_bit_alone: assert property (
        s_rd(4'h4) |=> read_data[7:1] == 7'h00) else $error("top bit");
    a_flush_pulse: assert property (
        s_rd(4'h1) |=> !read_data[7]) else $error("flush stuck");
    a_wait_readback: assert property (
        p_back(lbu_pkg::ADDR_PARAM_ONE_LOW)) else $error("param one");
    a_limit_readback: assert property (
        p_back(lbu_pkg::ADDR_PARAM_TWO)) else $error("param two");
    a_baud_readback: assert property (
        p_back(lbu_pkg::ADDR_BAUD_LOW)) else $error("divisor");
    a_start_width: assert property (
        $fell(tx_pin) |-> (!tx_pin) [*8]) else $error("start bit");
endmodule // lbu_uart_props

bind lbu_uart lbu_uart_props u_props (.clock(clock), .reset_n(reset_n),
    .address(address), .write_data(write_data), .rx_pin(rx_pin),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .tx_pin(tx_pin));

// ==== test/lbu_bus_model.sv ====
/* lbu_bus_model: another party on the shared wired-and line.
   assumes: 8 clocks per bit; the line idles high. */
`timescale 1ns/1ps
module lbu_bus_model (
    input wire logic clock,
    input wire logic tx_pin,
    output logic     rx_pin
);
    logic drive_reg = 1'b1;
    // either party pulls the line low
    assign rx_pin = tx_pin & drive_reg;
    ////////////////////////////////////////
    task automatic send(input logic [7:0] b, input int idle);
        logic [10:0] bits;
        bits = {2'b11, b, 1'b0};
        repeat (idle) @(posedge clock);
        for (int i = 0; i < 11; i++) begin
            drive_reg <= bits[i];
            repeat (8) @(posedge clock);
        end
    endtask
endmodule // lbu_bus_model

// ==== test/testbench.sv ====
/* testbench: registers, controller, flush and gear runs of lbu_uart.
   assumes: lbu_bus_model shares the line; half bit is 4 clocks. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
    logic        clock, reset_n, write_strobe, read_strobe, rx_pin, tx_pin;
    logic        pend = 1'b0;
    logic [3:0]  address;
    logic [7:0]  write_data, read_data, r, v;
    logic [15:0] note;
    logic [15:0] notes[$];
    int          errors = 0, tests_run = 0, cyc = 0, t0, k;
    lbu_uart uut (.clock(clock), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data),
        .rx_pin(rx_pin), .tx_pin(tx_pin));
    lbu_bus_model peer (.clock(clock), .tx_pin(tx_pin), .rx_pin(rx_pin));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////
    always @(posedge clock) begin
        cyc <= cyc + 1;
        pend <= read_strobe;
        if (pend) begin
            note = notes.pop_front();
            if (note[15:8] != 8'h00)
                `CHK("read_data", note[7:0], read_data & note[15:8])
        end
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        notes.push_back({m, e & m});
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 v = read_data;
    endtask
    // write, then read back at once when m is not zero
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [7:0] m = 8'h00, e = 8'h00);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        if (m != 8'h00) begin
            read_strobe <= 1'b1;
            notes.push_back({m, e & m});
            @(posedge clock);
            read_strobe <= 1'b0;
        end
    endtask
    task automatic wait_rx();
        v = 8'h00;
        for (int i = 0; i < 300 && v[1] !== 1'b1; i++)
            rd(4'h2, 8'h00, 8'h00);
        `CHK("rx flag", 1'b1, v[1])
    endtask
    task automatic wait_lvl(input logic lv, input int n);
        for (k = 0; k < n && tx_pin !== lv; k++)
            @(posedge clock);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        {reset_n, write_strobe, read_strobe, address, write_data} = '0;
        r = 8'($urandom(84));
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd(4'h3, 8'hFF, 8'h00);
        rd(4'h4, 8'hFF, 8'h00);
        wr(4'h4, r, 8'hFF, {7'h00, r[0]});
        r = 8'($urandom);
        wr(4'h5, r, 8'hFF, r);
        rd(4'hC, 8'hFF, 8'h00);
        $display("test registers done");
        wr(4'h8, 8'h03, 8'hFF, 8'h03);
        wr(4'h9, 8'h00);
        wr(4'h1, {6'h00, lbu_pkg::STOP_TWO});
        wr(4'h3, 8'h04, 8'hFF, 8'h04);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h02);
        wr(4'h0, {4'h3, lbu_pkg::MODE_CONTROLLER});
        wr(4'h6, 8'hFF);
        wr(4'h6, r);
        wait_lvl(1'b0, 200);
        t0 = cyc;
        wait_lvl(1'b1, 200);
        wait_lvl(1'b0, 200);
        `CHK("gap", 1'b1, cyc - t0 >= 104 && cyc - t0 <= 108)
        wait_rx();
        rd(4'h2, 8'h04, 8'h04);
        rd(4'h7, 8'hFF, 8'hFF);
        wait_rx();
        rd(4'h7, 8'hFF, r);
        $display("test controller done");
        wr(4'h3, 8'hFF);
        wr(4'h4, 8'h01);
        wr(4'h6, r);
        repeat (200) @(posedge clock);
        wr(4'h6, 8'h5A);
        wr(4'h1, {6'h20, lbu_pkg::STOP_TWO}, 8'hFF, 8'h02);
        t0 = cyc;
        wr(4'h6, ~r);
        wait_lvl(1'b0, 3000);
        `CHK("wait", 1'b1, cyc - t0 > 1880 && cyc - t0 < 1980)
        wait_rx();
        rd(4'h7, 8'hFF, r);
        repeat (100) @(posedge clock);
        rd(4'h7, 8'hFF, ~r);
        $display("test flush done");
        wr(4'h3, 8'h28);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h3C);
        wr(4'h0, {4'h3, lbu_pkg::MODE_GEAR});
        for (int j = 0; j < 2; j++) begin
            r = 8'($urandom);
            peer.send(r, 300);
            t0 = cyc;
            wait_rx();
            rd(4'h7, 8'hFF, r);
            if (j == 0)
                wr(4'h6, ~r);
            rd(4'h2, 8'h01, 8'h00);
            wait_lvl(1'b0, 400);
            `CHK("delay", 1'b1, cyc - t0 > 140 && cyc - t0 < 190)
            repeat (150) @(posedge clock);
            rd(4'h2, 8'h02, 8'h00);
            if (j == 0) begin
                wr(4'h6, r);
                wait_lvl(1'b0, 500);
                `CHK("late", 500, k)
            end
        end
        wr(4'h6, 8'hA5);
        wr(4'h1, {6'h20, lbu_pkg::STOP_TWO});
        peer.send(8'h3C, 300);
        wait_lvl(1'b0, 400);
        `CHK("flushed", 400, k)
        $display("test gear done");
        results();
    end
endmodule // testbench
